// [rtl/byte_ram.v]
/*
 * Byte-wide storage with one write port and one read port.
 * Read is combinational; the parent registers what it returns.
 * Assumes a single clock; no reset of contents.
 */
`timescale 1ns/1ns
`default_nettype none

module byte_ram #(
	parameter AW = 9
) (
	// clock
	input wire ref_clk,
	// write port
	input wire we,
	input wire [AW-1:0] waddr,
	input wire [7:0] wdata,
	// read port
	input wire [AW-1:0] raddr,
	output wire [7:0] rdata
);

reg [7:0] mem [0:(1<<AW)-1];

// contents persist across page pointer and mode changes
always @(posedge ref_clk)
begin
	if (we)
	begin
		mem[waddr] <= wdata;
	end
end

assign rdata = mem[raddr];

endmodule // byte_ram

`default_nettype wire

// [rtl/cmd_block_defs.vh]
/*
 * Constants for the command block array and input queue block:
 * register offsets, field positions, reset values and queue limits.
 * Assumes it is included by bare name from the design files.
 */
`ifndef CMD_BLOCK_DEFS_VH
`define CMD_BLOCK_DEFS_VH

// register byte offsets, shared by host and sequencer
`define OFS_PAGE_PTR 8'h90
`define OFS_BYTE_CNT 8'h9A
`define OFS_QUEUE 8'h9B
`define OFS_QCOUNT 8'h9C
`define OFS_ARRAY_LO 8'hA0
`define OFS_ARRAY_HI 8'hBF

// page byte counter fields
`define CNT_AUTO_BIT 7
`define CNT_OFS_HI 4
`define CNT_LANE_LAST 2'h3

// reset values
`define PAGE_PTR_RST 8'h00
`define BYTE_CNT_RST 5'h00
`define QCOUNT_RST 8'h00

// queue limits: count saturates here; 16 slots internal, 256 external
`define QCOUNT_MAX 8'hFF
`define QCOUNT_EMPTY 8'h00

// internal storage: 16 pages of 32 bytes
`define INT_RAM_AW 9
`define EXT_RAM_AW 13

// pci register port state codes
`define PST_IDLE 2'h0
`define PST_UNPACK 2'h1
`define PST_EXTRD 2'h2

`endif

// [rtl/command_block_array_queue.v]
/*
 * Command block array access and input command queue.
 * Holds the page pointer, the auto offset byte counter and the
 * input queue, and steers array bytes to internal or external SRAM.
 * Assumes a host register port (PCI target data phases already decoded
 * to a request level) and a sequencer byte port, both on ref_clk.
 */
`timescale 1ns/1ns
`default_nettype none
`include "cmd_block_defs.vh"

module command_block_array_queue (
	// clock and reset
	input wire ref_clk,
	input wire rst_n,
	// storage mode
	input wire external_block_ram_mode,
	// host register port
	input wire pci_req,
	input wire pci_write,
	input wire [7:0] pci_addr,
	input wire [3:0] pci_cbe_n,
	input wire [31:0] pci_wdata,
	output reg pci_trdy,
	output reg [31:0] pci_rdata,
	// sequencer register port
	input wire seq_rd,
	input wire seq_wr,
	input wire [7:0] seq_raddr,
	input wire [7:0] seq_waddr,
	input wire [7:0] seq_wdata,
	output wire seq_hold,
	output reg seq_rvalid,
	output reg [7:0] seq_rdata,
	// external block SRAM
	output reg ext_we,
	output reg [12:0] ext_waddr,
	output reg [7:0] ext_wdata,
	output reg ext_re,
	output reg [12:0] ext_raddr,
	input wire [7:0] ext_rdata
);

// register state
reg [7:0] command_page_pointer;
reg auto_offset_enable;
reg [4:0] page_byte_counter;
reg [7:0] input_queue_count;
reg [7:0] q_wptr;
reg [7:0] q_rptr;
reg [3:0] small_queue [0:15];
reg [1:0] pst;
// external read pipeline: stage 1 has ext_re out, stage 2 samples data
reg ext_cap;
reg tag1_seq;
reg tag2_seq;
// unified access of this cycle
reg acc_wr;
reg [7:0] acc_waddr;
reg [7:0] acc_wdata;
reg acc_rd;
reg [7:0] acc_raddr;
reg acc_seq;
reg [1:0] lane;
wire ext_mode = external_block_ram_mode;
wire [7:0] ram_q;
wire [7:0] queue_head;
// sequencer is refused only while its own external read is in flight
assign seq_hold = (ext_re & tag1_seq) | (ext_cap & tag2_seq);
wire seq_take = (seq_rd | seq_wr) & ~seq_hold;
// byte enable decode: lowest enabled lane, exact single and full patterns
wire cbe_one = (pci_cbe_n == 4'hE) | (pci_cbe_n == 4'hD) |
	(pci_cbe_n == 4'hB) | (pci_cbe_n == 4'h7);
wire cbe_all = (pci_cbe_n == 4'h0);

always @*
begin
	casez (pci_cbe_n)
	4'b???0: lane = 2'h0;
	4'b??01: lane = 2'h1;
	4'b?011: lane = 2'h2;
	default: lane = 2'h3;
	endcase
end

wire [7:0] pci_off = {pci_addr[7:2], lane};
wire pci_in_array = (pci_off >= `OFS_ARRAY_LO) && (pci_off <= `OFS_ARRAY_HI);
// host requests only start when the sequencer is not using the port
wire pci_go = (pst == `PST_IDLE) & pci_req & ~pci_trdy & ~seq_take;
wire pci_dword = pci_write & auto_offset_enable & cbe_all &
	pci_in_array;
wire pci_byte_wr = pci_go & pci_write & cbe_one;
wire pci_rd = pci_go & ~pci_write;
wire pci_unpack = (pst == `PST_UNPACK) & ~seq_take;
// one byte mux: unpacking follows counter bits 1:0, not the enables
wire [1:0] byte_sel = pci_unpack ? page_byte_counter[1:0] : lane;
wire [7:0] sel_byte = pci_wdata[{byte_sel, 3'b000} +: 8];

// merge both ports into one access; the sequencer has priority
always @*
begin
	acc_wr = 1'b0;
	acc_waddr = 8'h00;
	acc_wdata = 8'h00;
	acc_rd = 1'b0;
	acc_raddr = 8'h00;
	acc_seq = 1'b0;
	if (seq_take)
	begin
		acc_seq = 1'b1;
		acc_wr = seq_wr;
		acc_waddr = seq_waddr;
		acc_wdata = seq_wdata;
		acc_rd = seq_rd;
		acc_raddr = seq_raddr;
	end
	else if (pci_unpack)
	begin
		acc_wr = 1'b1;
		acc_waddr = `OFS_ARRAY_LO;
		acc_wdata = sel_byte;
	end
	else if (pci_byte_wr & ~pci_dword)
	begin
		acc_wr = 1'b1;
		acc_waddr = pci_off;
		acc_wdata = sel_byte;
	end
	else if (pci_rd)
	begin
		acc_rd = 1'b1;
		acc_raddr = pci_off; // reads use one byte only
	end
end

// address decode of the merged access
wire wr_arr = acc_wr && (acc_waddr >= `OFS_ARRAY_LO) &&
	(acc_waddr <= `OFS_ARRAY_HI);
wire rd_arr = acc_rd && (acc_raddr >= `OFS_ARRAY_LO) &&
	(acc_raddr <= `OFS_ARRAY_HI);
wire wr_ptr = acc_wr && (acc_waddr == `OFS_PAGE_PTR);
wire wr_cnt = acc_wr && (acc_waddr == `OFS_BYTE_CNT);
wire enq = acc_wr && (acc_waddr == `OFS_QUEUE);
wire deq = acc_rd && acc_seq && (acc_raddr == `OFS_QUEUE);
wire enq_ok = enq && (input_queue_count != `QCOUNT_MAX);
wire deq_ok = deq && (input_queue_count != `QCOUNT_EMPTY);
// byte offset within the page: counter in auto mode, else the address
wire [4:0] widx = auto_offset_enable ? page_byte_counter :
	acc_waddr[4:0];
wire [4:0] ridx = auto_offset_enable ? page_byte_counter :
	acc_raddr[4:0];
wire cnt_inc = auto_offset_enable & (wr_arr | rd_arr);
// internal SRAM holds blocks, or the queue in external mode
wire int_we = ext_mode ? enq_ok : wr_arr;
wire [8:0] int_waddr = ext_mode ? {1'b0, q_wptr} :
	{command_page_pointer[3:0], widx};
wire [8:0] int_raddr = ext_mode ? {1'b0, q_rptr} :
	{command_page_pointer[3:0], ridx};
wire ext_rd_issue = rd_arr & ext_mode;

byte_ram #(
	.AW(`INT_RAM_AW)
) int_sram (
	.ref_clk(ref_clk),
	.we(int_we),
	.waddr(int_waddr),
	.wdata(acc_wdata),
	.raddr(int_raddr),
	.rdata(ram_q)
);
// internal mode keeps only four bits of each entry
assign queue_head = ext_mode ? ram_q :
	{4'h0, small_queue[q_rptr[3:0]]};
// read value of the merged access; unmapped offsets read zero
wire [7:0] rd_val = rd_arr ? ram_q :
	(acc_raddr == `OFS_PAGE_PTR) ? command_page_pointer :
	(acc_raddr == `OFS_BYTE_CNT) ?
	{auto_offset_enable, 2'b00, page_byte_counter} :
	(acc_raddr == `OFS_QUEUE) ? queue_head :
	(acc_raddr == `OFS_QCOUNT) ? input_queue_count :
	8'h00;

// page pointer keeps all eight bits even with 16 internal pages
always @(posedge ref_clk)
begin
	if (!rst_n)
		command_page_pointer <= `PAGE_PTR_RST;
	else if (wr_ptr)
		command_page_pointer <= acc_wdata;
end

// counter: a register write wins over the auto increment
always @(posedge ref_clk)
begin
	if (!rst_n)
	begin
		auto_offset_enable <= 1'b0;
		page_byte_counter <= `BYTE_CNT_RST;
	end
	else if (wr_cnt)
	begin
		auto_offset_enable <= acc_wdata[`CNT_AUTO_BIT];
		page_byte_counter <= acc_wdata[`CNT_OFS_HI:0];
	end
	else if (cnt_inc)
	begin
		page_byte_counter <= page_byte_counter + 5'h01;
	end
end

// queue pointers and count; the count rolls past 16 in internal mode
always @(posedge ref_clk)
begin
	if (!rst_n)
	begin
		input_queue_count <= `QCOUNT_RST;
		q_wptr <= 8'h00;
		q_rptr <= 8'h00;
	end
	else
	begin
		if (enq_ok)
			q_wptr <= q_wptr + 8'h01;
		if (deq_ok)
			q_rptr <= q_rptr + 8'h01;
		if (enq_ok & ~deq_ok)
			input_queue_count <= input_queue_count + 8'h01;
		else if (deq_ok & ~enq_ok)
			input_queue_count <= input_queue_count - 8'h01;
	end
end

// internal mode queue storage, 16 slots of four bits
always @(posedge ref_clk)
begin
	if (enq_ok & ~ext_mode)
		small_queue[q_wptr[3:0]] <= acc_wdata[3:0];
end

// external SRAM strobes, registered one cycle after the access
always @(posedge ref_clk)
begin
	if (!rst_n)
	begin
		ext_we <= 1'b0;
		ext_waddr <= 13'h0000;
		ext_wdata <= 8'h00;
		ext_re <= 1'b0;
		ext_raddr <= 13'h0000;
		ext_cap <= 1'b0;
		tag1_seq <= 1'b0;
		tag2_seq <= 1'b0;
	end
	else
	begin
		ext_we <= wr_arr & ext_mode;
		ext_waddr <= {command_page_pointer, widx};
		ext_wdata <= acc_wdata;
		ext_re <= ext_rd_issue;
		ext_raddr <= {command_page_pointer, ridx};
		tag1_seq <= ext_rd_issue & acc_seq;
		ext_cap <= ext_re;
		tag2_seq <= tag1_seq;
	end
end

// sequencer read answers: one cycle internal, three cycles external
always @(posedge ref_clk)
begin
	if (!rst_n)
	begin
		seq_rvalid <= 1'b0;
		seq_rdata <= 8'h00;
	end
	else if (ext_cap & tag2_seq)
	begin
		seq_rvalid <= 1'b1;
		seq_rdata <= ext_rdata;
	end
	else if (acc_seq & acc_rd & ~ext_rd_issue)
	begin
		seq_rvalid <= 1'b1;
		seq_rdata <= rd_val;
	end
	else
	begin
		seq_rvalid <= 1'b0;
	end
end

// host data phase control; trdy is a one-cycle completion pulse
always @(posedge ref_clk)
begin
	if (!rst_n)
	begin
		pst <= `PST_IDLE;
		pci_trdy <= 1'b0;
		pci_rdata <= 32'h00000000;
	end
	else
	begin
		pci_trdy <= 1'b0;
		case (pst)
		`PST_IDLE:
		begin
			if (pci_go & pci_dword)
				pst <= `PST_UNPACK;
			else if (pci_go & pci_write)
				pci_trdy <= 1'b1; // odd enable patterns complete unused
			else if (pci_rd & ext_rd_issue)
				pst <= `PST_EXTRD;
			else if (pci_rd)
			begin
				pci_rdata <= {4{rd_val}};
				pci_trdy <= 1'b1;
			end
		end
		`PST_UNPACK:
		begin
			// trdy stays low until lane 3 is stored
			if (pci_unpack &&
				page_byte_counter[1:0] == `CNT_LANE_LAST)
			begin
				pci_trdy <= 1'b1;
				pst <= `PST_IDLE;
			end
		end
		`PST_EXTRD:
		begin
			if (ext_cap & ~tag2_seq)
			begin
				pci_rdata <= {4{ext_rdata}};
				pci_trdy <= 1'b1;
				pst <= `PST_IDLE;
			end
		end
		default:
		begin
			pst <= `PST_IDLE;
		end
		endcase
	end
end

endmodule // command_block_array_queue

`default_nettype wire

// [sim/command_block_array_queue_properties.sv]
/*
 * Concurrent checks on the command block array and input queue ports.
 * Assumes it is bound into the design top; watches a subset of ports.
 */
`timescale 1ns/1ns
`default_nettype none
module command_block_array_queue_properties (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// mode and host port
	input wire logic external_block_ram_mode,
	input wire logic pci_write,
	input wire logic pci_trdy,
	input wire logic [31:0] pci_rdata,
	// sequencer port
	input wire logic seq_rd,
	input wire logic [7:0] seq_raddr,
	input wire logic seq_hold,
	input wire logic seq_rvalid,
	input wire logic [7:0] seq_rdata,
	// external sram strobes
	input wire logic ext_we,
	input wire logic ext_re
);
	// one clock domain, so clock and reset are given once
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	a_trdy_one_cycle: assert property (pci_trdy |=> !pci_trdy)
		else $error("trdy held past one cycle");
	// back to back reads may give valid every cycle; a held read must answer
	a_hold_ends_valid: assert property ($fell(seq_hold) |-> seq_rvalid)
		else $error("held read ended without data");
	a_ext_we_mode: assert property (ext_we |-> external_block_ram_mode)
		else $error("external write in internal mode");
	a_ext_re_mode: assert property (ext_re |-> external_block_ram_mode)
		else $error("external read in internal mode");
	a_hold_mode: assert property (seq_hold |-> external_block_ram_mode)
		else $error("sequencer held in internal mode");
	// a host read returns one byte, seen on every lane
	a_read_byte_lanes: assert property (pci_trdy && !pci_write |->
		pci_rdata == {4{pci_rdata[7:0]}}) else $error("read not byte wide");
	a_rvalid_cause: assert property (seq_rvalid |->
		$past(seq_rd) || $past(seq_rd, 3)) else $error("valid without read");
	a_entry_high_zero: assert property (seq_rvalid &&
		!external_block_ram_mode && $past(seq_rd) &&
		$past(seq_raddr) == 8'h9B |-> seq_rdata[7:4] == 4'h0)
		else $error("queue entry high bits set");
	c_host_write: cover property (pci_trdy && pci_write);
	c_ext_seq_read: cover property (seq_rvalid && external_block_ram_mode);
	c_ext_write: cover property (ext_we);
endmodule // command_block_array_queue_properties

bind command_block_array_queue command_block_array_queue_properties u_props (
	.ref_clk(ref_clk), .rst_n(rst_n),
	.external_block_ram_mode(external_block_ram_mode),
	.pci_write(pci_write), .pci_trdy(pci_trdy), .pci_rdata(pci_rdata),
	.seq_rd(seq_rd), .seq_raddr(seq_raddr), .seq_hold(seq_hold),
	.seq_rvalid(seq_rvalid), .seq_rdata(seq_rdata),
	.ext_we(ext_we), .ext_re(ext_re)
);
`default_nettype wire

// [sim/ext_block_sram.sv]
/*
 * Behavioural external block sram, separate read and write addresses.
 * Assumes read data is wanted the cycle after the read strobe.
 */
`timescale 1ns/1ns
`default_nettype none
module ext_block_sram (
	// clock
	input wire logic ref_clk,
	// write side
	input wire logic ext_we,
	input wire logic [12:0] ext_waddr,
	input wire logic [7:0] ext_wdata,
	// read side
	input wire logic ext_re,
	input wire logic [12:0] ext_raddr,
	output var logic [7:0] ext_rdata
);
	logic [7:0] mem [0:8191];
	initial ext_rdata = 8'h00;
	// idle data toggles so a late sample never sees the old byte
	always @(posedge ref_clk)
	begin
		if (ext_we)
			mem[ext_waddr] <= ext_wdata;
		if (ext_re)
			ext_rdata <= mem[ext_raddr];
		else
			ext_rdata <= ~ext_rdata;
	end
endmodule // ext_block_sram
`default_nettype wire

// [sim/test_command_block_array_queue.sv]
/*
 * Self-checking bench: host and sequencer drivers note expectations,
 * a watcher compares results. Assumes design and sram model compiled.
 */
`timescale 1ns/1ns
`default_nettype none
module test_command_block_array_queue;
	logic ref_clk = 0, rst_n = 0, ram_mode = 0, pci_req = 0, pci_write = 0;
	logic seq_rd = 0, seq_wr = 0, seq_hold, seq_rvalid, pci_trdy;
	logic ext_we, ext_re;
	logic [3:0] pci_cbe_n = 4'hF;
	logic [7:0] seq_raddr = 0, seq_waddr = 0, seq_wdata = 0, seq_rdata;
	logic [7:0] ext_wdata, ext_rdata;
	logic [12:0] ext_waddr, ext_raddr;
	logic [7:0] pci_addr = 0, q [0:2];
	logic [31:0] pci_wdata = 0, pci_rdata, r = 32'h776BB8CA;
	logic [31:0] pq [$];
	logic [7:0] sq [$];
	int num_errors = 0, checks = 0, n, k, m;
	always #2 ref_clk = ~ref_clk;
	command_block_array_queue u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.external_block_ram_mode(ram_mode), .pci_req(pci_req),
		.pci_write(pci_write), .pci_addr(pci_addr), .pci_cbe_n(pci_cbe_n),
		.pci_wdata(pci_wdata), .pci_trdy(pci_trdy), .pci_rdata(pci_rdata),
		.seq_rd(seq_rd), .seq_wr(seq_wr), .seq_raddr(seq_raddr),
		.seq_waddr(seq_waddr), .seq_wdata(seq_wdata), .seq_hold(seq_hold),
		.seq_rvalid(seq_rvalid), .seq_rdata(seq_rdata), .ext_we(ext_we),
		.ext_waddr(ext_waddr), .ext_wdata(ext_wdata), .ext_re(ext_re),
		.ext_raddr(ext_raddr), .ext_rdata(ext_rdata));
	ext_block_sram u_sram (.ref_clk(ref_clk), .ext_we(ext_we),
		.ext_waddr(ext_waddr), .ext_wdata(ext_wdata), .ext_re(ext_re),
		.ext_raddr(ext_raddr), .ext_rdata(ext_rdata));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("[ERR] %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// host data phase, held until trdy; released lines show inverse data
	task automatic pci(input logic w, input logic [7:0] a,
		input logic [3:0] be, input logic [31:0] d, output int c);
		c = 0;
		@(posedge ref_clk);
		pci_req <= 1;
		pci_write <= w;
		pci_addr <= a;
		pci_cbe_n <= be;
		pci_wdata <= d;
		do
		begin
			@(posedge ref_clk);
			c++;
		end
		while (pci_trdy !== 1'b1 && c < 60);
		pci_req <= 0;
		pci_wdata <= ~d;
		if (c == 60)
			check(0, 1);
	endtask
	// byte lane follows the low address bits, data on every lane
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		pci(1, a, ~(4'h1 << a[1:0]), {4{d}}, n);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		pq.push_back({4{e}});
		pci(0, a, ~(4'h1 << a[1:0]), r, n);
	endtask
	// sequencer request, repeated while held off
	task automatic seq(input logic rr, input logic ww, input logic [7:0] ra,
		input logic [7:0] wa, input logic [7:0] wd);
		int c;
		c = 0;
		@(posedge ref_clk);
		seq_rd <= rr;
		seq_wr <= ww;
		seq_raddr <= ra;
		seq_waddr <= wa;
		seq_wdata <= wd;
		do
		begin
			@(posedge ref_clk);
			c++;
		end
		while (seq_hold === 1'b1 && c < 20);
		seq_rd <= 0;
		seq_wr <= 0;
		seq_raddr <= ~ra;
		seq_wdata <= ~wd;
		if (c == 20)
			check(0, 1);
	endtask
	task automatic sr(input logic [7:0] a, input logic [7:0] e);
		sq.push_back(e);
		seq(1, 0, a, 8'h00, 8'h00);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0 && pq.size() == 0 && sq.size() == 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// result watcher: oldest note against each read answer
	always @(posedge ref_clk)
	begin
		if (pci_trdy === 1'b1 && pci_write === 1'b0)
			check(pq.size() ? pq.pop_front() : 32'hX, pci_rdata);
		if (seq_rvalid === 1'b1)
			check(sq.size() ? {24'h0, sq.pop_front()} : 32'hX, {24'h0, seq_rdata});
	end
	// hang guard at 25000 cycles, far beyond the 1200 or so needed
	initial
	begin
		#100000;
		num_errors++;
		wrap_up();
	end
	initial
	begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1;
		rd(8'h90, 8'h00);
		rd(8'h9A, 8'h00);
		rd(8'h9C, 8'h00);
		rd(8'h91, 8'h00);
		$display("test reset values done");
		for (m = 0; m < 2; m++)
		begin
			ram_mode <= m[0];
			wr(8'h90, 8'hFF);
			rd(8'h90, 8'hFF);
			wr(8'h90, 8'h03);
			wr(8'h9A, 8'h84);
			r = lfsr(r);
			pci(1, 8'hA0, 4'h0, r, n);
			check(1, n > 5);
			rd(8'h9A, 8'h88);
			// auto offset reads: host then sequencer walk the same counter
			wr(8'h9A, 8'h84);
			rd(8'hA0, r[7:0]);
			sr(8'hA0, r[15:8]);
			wr(8'h90, 8'h04);
			wr(8'h9A, 8'h00);
			seq(0, 1, 8'h00, 8'hA4, 8'h5A);
			seq(1, 1, 8'hA4, 8'hA8, 8'hC3);
			sq.push_back(8'h5A);
			sr(8'hA8, 8'hC3);
			wr(8'h90, 8'h03);
			for (k = 0; k < 4; k++)
				sr(8'hA4 + k[7:0], r[8 * k +: 8]);
			rd(8'hA7, r[31:24]);
			$display("test array mode %0d done", m);
		end
		for (k = 0; k < 256; k++)
			seq(0, 1, 8'h00, 8'h9B, k[7:0]);
		rd(8'h9C, 8'hFF);
		for (k = 0; k < 255; k++)
			sr(8'h9B, k[7:0]);
		rd(8'h9C, 8'h00);
		ram_mode <= 0;
		for (k = 0; k < 3; k++)
		begin
			r = lfsr(r);
			q[k] = r[7:0];
			wr(8'h9B, r[7:0]);
		end
		rd(8'h9C, 8'h03);
		for (k = 0; k < 3; k++)
			sr(8'h9B, {4'h0, q[k][3:0]});
		$display("test queue done");
		repeat (5) @(posedge ref_clk);
		wrap_up();
	end
endmodule // test_command_block_array_queue
`default_nettype wire
